// ===== inc/scel_pkg.sv
// Shared constants and types for the sensor calibration loader
package scel_pkg;

  // Calibration memory geometry
  localparam int unsigned MEM_BYTES   = 768;
  localparam int unsigned PAGE_COUNT  = 12;
  localparam int unsigned PAGE_BYTES  = 64;
  localparam int unsigned MEM_AW      = 10;

  // Fixed word locations (low byte at even address)
  localparam logic [9:0]  OFS_TABLE_BASE  = 10'h000;
  localparam logic [9:0]  SPAN_LOW_BASE   = 10'h200;
  localparam logic [9:0]  SPAN_HIGH_BASE  = 10'h1a0;
  localparam logic [7:0]  SPAN_SPLIT_IDX  = 8'h80;
  localparam logic [7:0]  LAST_IDX        = 8'haf;
  localparam logic [9:0]  CONFIG_ADDR     = 10'h160;
  localparam logic [9:0]  OFS_TEMPCO_ADDR = 10'h164;
  localparam logic [9:0]  SPAN_TEMPCO_ADDR = 10'h168;
  localparam logic [9:0]  LOCK_ADDR       = 10'h16a;
  localparam logic [7:0]  LOCK_OPEN       = 8'h00;

  // Calibration register slots
  localparam logic [2:0]  SLOT_CONFIG      = 3'h0;
  localparam logic [2:0]  SLOT_OFS_TRIM    = 3'h1;
  localparam logic [2:0]  SLOT_OFS_TEMPCO  = 3'h2;
  localparam logic [2:0]  SLOT_SPAN_TEMPCO = 3'h3;
  localparam logic [2:0]  SLOT_SPAN_TRIM   = 3'h4;
  localparam logic [2:0]  SLOT_COUNT       = 3'h5;

  // Serial framing and command set
  localparam logic [7:0]  INIT_BYTE    = 8'h01;
  localparam logic [7:0]  REINIT_BYTE  = 8'hff;
  localparam logic [3:0]  CMD_ADDR     = 4'h9;
  localparam int unsigned PRESCALE_LOG = 5;
  localparam logic [7:0]  BPC_MAX      = 8'hff;

  // Register port map (word per address)
  localparam logic [11:0] REG_STATUS   = 12'h400;
  localparam logic [11:0] REG_BITCOUNT = 12'h401;
  localparam logic [11:0] REG_ERASE    = 12'h402;
  localparam logic [11:0] REG_CAL_BASE = 12'h410;

  // Refresh timing
  localparam int unsigned CLK_MHZ         = 20;
  localparam int unsigned REFRESH_TIME_US = 1000;
  localparam int unsigned REFRESH_CYC     = REFRESH_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic [15:0] config_word;
    logic [15:0] offset_trim_word;
    logic [15:0] offset_tempco_word;
    logic [15:0] span_tempco_word;
    logic [15:0] span_trim_word;
  } scel_cal_t;

endpackage

// ===== hdl/scel_loader.sv
// Calibration memory, autoload, temperature lookup and baud-learning serial receiver
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps

// Overview of operation
// - Unlocked or unlock pin high: serial commands load calibration registers.
// - Memory is 768 bytes in 12 pages of 64; pages erase separately.
// - Offset table spans 0x000..0x15F, entry n at byte 2n.
// - Span table: indices 0x00-0x7F at 0x200, 0x80-0xAF at 0x1A0.
// - Words are two bytes, low byte even address, high byte next.
// - Registers autoload from memory after every power-up.
// - Config 0x160, offset tempco 0x164, span tempco 0x168, lock 0x16A.
// - Offset and span trim come from tables indexed by temperature pointer.
// - Every 1 ms the 8-bit temperature code is stored as pointer.
// - Each pointer value fetches two consecutive bytes as one word.
// - Pointers above 0xAF clamp to last entry; no wraparound.
// - Lock byte zero makes the data pin a serial input.
// - Each received command writes one of sixteen interface registers.
// - A 16-bit holding latch carries every register transfer.
// - Baud rate 4800..38400 is learned from the initialization byte.
// - Characters: start bit, eight data bits LSB first, stop bit.
// - Line idles high; any falling edge starts a character.
// - Serial pin is ignored unless unlocked or unlock pin high.
// - First byte after power-up or reinit is 0x01 for baud learning.
// - One bit period is stored as an 8-bit count of 32-clock units.
// - Byte 0xFF returns the receiver to its power-up state.
module scel_loader
  import scel_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        unlock_pin,
  input  wire logic [7:0]  temp_code,
  input  wire logic        single_pin_serial_io_i,
  output logic             single_pin_serial_io_o,
  output logic             single_pin_serial_io_oe,
  input  wire logic [11:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output scel_cal_t        cal_words,
  output logic             serial_enabled
);

  typedef enum logic [2:0] {
    RX_OFF, RX_WAIT_INIT, RX_MEASURE, RX_SKIP, RX_IDLE, RX_START, RX_DATA, RX_STOP
  } scel_rx_state_t;

  typedef enum logic [1:0] {
    LD_IDLE, LD_LOW, LD_HIGH, LD_STORE
  } scel_ld_state_t;

  // Word address of a calibration slot for the current pointer
  function automatic logic [9:0] scel_word_addr(input logic [2:0] slot, input logic [7:0] ptr);
    logic [7:0] idx;
    logic [9:0] res;
    idx = (ptr > LAST_IDX) ? LAST_IDX : ptr;
    res = CONFIG_ADDR;
    case (slot)
      SLOT_OFS_TRIM:    res = OFS_TABLE_BASE + {1'b0, idx, 1'b0};
      SLOT_OFS_TEMPCO:  res = OFS_TEMPCO_ADDR;
      SLOT_SPAN_TEMPCO: res = SPAN_TEMPCO_ADDR;
      SLOT_SPAN_TRIM:
        if (idx < SPAN_SPLIT_IDX) begin
          res = SPAN_LOW_BASE + {1'b0, idx, 1'b0};
        end else begin
          res = SPAN_HIGH_BASE + {1'b0, idx - SPAN_SPLIT_IDX, 1'b0};
        end
      default:          res = CONFIG_ADDR;
    endcase
    return res;
  endfunction

  // Calibration byte array, not reset like the non-volatile store it models
  logic [7:0]           mem [MEM_BYTES];
  logic                 rx_prev_q;
  logic                 rx_prev_d;
  scel_rx_state_t       rx_state_q;
  scel_rx_state_t       rx_state_d;
  logic [15:0]          tmr_q;
  logic [15:0]          tmr_d;
  logic [7:0]           bpc_q;
  logic [7:0]           bpc_d;
  logic                 learned_q;
  logic                 learned_d;
  logic [7:0]           shift_q;
  logic [7:0]           shift_d;
  logic [2:0]           bitn_q;
  logic [2:0]           bitn_d;
  logic [15:0][3:0]     command_register_set_q;
  logic [15:0][3:0]     command_register_set_d;
  logic                 cmd_fire;
  logic [3:0]           cmd_nibble;
  scel_ld_state_t       ld_state_q;
  scel_ld_state_t       ld_state_d;
  logic [2:0]           slot_q;
  logic [2:0]           slot_d;
  logic                 ser_load_q;
  logic                 ser_load_d;
  logic [15:0]          latch_q;
  logic [15:0]          latch_d;
  logic [4:0][15:0]     cal_q;
  logic [4:0][15:0]     cal_d;
  logic [7:0]           ptr_q;
  logic [7:0]           ptr_d;
  logic                 pend_q;
  logic                 pend_d;
  logic [31:0]          ref_q;
  logic [31:0]          ref_d;
  logic [15:0]          rdata_d;
  logic                 fall;
  logic [15:0]          bit_clk;
  logic [15:0]          half_clk;
  logic [15:0]          skip_clk;
  logic [9:0]           word_a;
  logic                 erase_hit;
  logic [3:0]           erase_page;

  // Serial access is open when the lock byte is cleared or the pin is high
  assign serial_enabled = (mem[LOCK_ADDR] == LOCK_OPEN) || unlock_pin;

  // Receive-only pin: never driven
  assign single_pin_serial_io_o  = 1'b1;
  assign single_pin_serial_io_oe = 1'b0;

  // Bit timing derived from the learned count (count is in 32-clock units)
  assign fall     = rx_prev_q && !single_pin_serial_io_i;
  assign bit_clk  = {bpc_q, 8'h00} >> (8 - PRESCALE_LOG);
  assign half_clk = bit_clk >> 1;
  assign skip_clk = {bit_clk[12:0], 3'h0} + half_clk;

  // Receiver next state
  always_comb begin
    rx_state_d = rx_state_q;
    tmr_d      = tmr_q;
    bpc_d      = bpc_q;
    learned_d  = learned_q;
    shift_d    = shift_q;
    bitn_d     = bitn_q;
    command_register_set_d = command_register_set_q;
    cmd_fire   = 1'b0;
    cmd_nibble = 4'h0;
    rx_prev_d  = single_pin_serial_io_i;
    case (rx_state_q)
      RX_OFF: begin
        if (serial_enabled) begin
          rx_state_d = RX_WAIT_INIT;
        end
      end
      RX_WAIT_INIT: begin
        tmr_d = 16'h0000;
        if (fall) begin
          rx_state_d = RX_MEASURE;
        end
      end
      RX_MEASURE: begin
        // Start bit alone is low since bit 0 of the init byte is one
        if (single_pin_serial_io_i) begin
          if (tmr_q[15:PRESCALE_LOG] > 11'(BPC_MAX)) begin
            bpc_d = BPC_MAX;
          end else if (tmr_q[12:PRESCALE_LOG] == 8'h00) begin
            bpc_d = 8'h01;
          end else begin
            bpc_d = tmr_q[12:PRESCALE_LOG];
          end
          learned_d  = 1'b1;
          tmr_d      = 16'h0000;
          rx_state_d = RX_SKIP;
        end else if (tmr_q != 16'hffff) begin
          tmr_d = tmr_q + 16'h0001;
        end
      end
      RX_SKIP: begin
        // Let the rest of the init character pass
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q >= skip_clk) begin
          rx_state_d = RX_IDLE;
        end
      end
      RX_IDLE: begin
        tmr_d = 16'h0000;
        if (fall) begin
          rx_state_d = RX_START;
        end
      end
      RX_START: begin
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q + 16'h0001 >= half_clk) begin
          tmr_d  = 16'h0000;
          bitn_d = 3'h0;
          rx_state_d = single_pin_serial_io_i ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q + 16'h0001 >= bit_clk) begin
          tmr_d   = 16'h0000;
          shift_d = {single_pin_serial_io_i, shift_q[7:1]};
          bitn_d  = bitn_q + 3'h1;
          if (bitn_q == 3'h7) begin
            rx_state_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        tmr_d = tmr_q + 16'h0001;
        if (tmr_q + 16'h0001 >= bit_clk) begin
          tmr_d      = 16'h0000;
          rx_state_d = RX_IDLE;
          if (single_pin_serial_io_i) begin
            if (shift_q == REINIT_BYTE) begin
              learned_d  = 1'b0;
              rx_state_d = RX_WAIT_INIT;
            end else begin
              command_register_set_d[shift_q[3:0]] = shift_q[7:4];
              cmd_fire   = (shift_q[3:0] == CMD_ADDR);
              cmd_nibble = shift_q[7:4];
            end
          end
        end
      end
      default: rx_state_d = RX_OFF;
    endcase
    if (!serial_enabled) begin
      rx_state_d = RX_OFF;
      learned_d  = 1'b0;
    end
  end

  // Receiver registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_q <= RX_OFF;
      rx_prev_q  <= 1'b1;
      tmr_q      <= 16'h0000;
      bpc_q      <= 8'h00;
      learned_q  <= 1'b0;
      shift_q    <= 8'h00;
      bitn_q     <= 3'h0;
      command_register_set_q <= '0;
    end else begin
      rx_state_q <= rx_state_d;
      rx_prev_q  <= rx_prev_d;
      tmr_q      <= tmr_d;
      bpc_q      <= bpc_d;
      learned_q  <= learned_d;
      shift_q    <= shift_d;
      bitn_q     <= bitn_d;
      command_register_set_q <= command_register_set_d;
    end
  end

  assign word_a = scel_word_addr(slot_q, ptr_q);

  // Loader next state: autoload, periodic refresh and serial loads
  always_comb begin
    ld_state_d = ld_state_q;
    slot_d     = slot_q;
    ser_load_d = ser_load_q;
    latch_d    = latch_q;
    cal_d      = cal_q;
    ptr_d      = ptr_q;
    pend_d     = pend_q;
    ref_d      = ref_q + 32'h1;
    if (ref_q >= REFRESH_CYCLES - 1) begin
      ref_d = 32'h0;
      ptr_d = temp_code;
      pend_d = !serial_enabled;
    end
    case (ld_state_q)
      LD_IDLE: begin
        if (cmd_fire && cmd_nibble < 4'(SLOT_COUNT)) begin
          latch_d    = {command_register_set_q[3], command_register_set_q[2],
                        command_register_set_q[1], command_register_set_q[0]};
          slot_d     = cmd_nibble[2:0];
          ser_load_d = 1'b1;
          ld_state_d = LD_STORE;
        end else if (pend_q) begin
          pend_d     = 1'b0;
          ptr_d      = temp_code;
          slot_d     = SLOT_CONFIG;
          ser_load_d = 1'b0;
          ld_state_d = LD_LOW;
        end
      end
      LD_LOW: begin
        latch_d[7:0] = mem[word_a];
        ld_state_d   = LD_HIGH;
      end
      LD_HIGH: begin
        latch_d[15:8] = mem[word_a + 10'h001];
        ld_state_d    = LD_STORE;
      end
      LD_STORE: begin
        cal_d[slot_q] = latch_q;
        if (ser_load_q || slot_q == SLOT_SPAN_TRIM) begin
          ld_state_d = LD_IDLE;
        end else begin
          slot_d     = slot_q + 3'h1;
          ld_state_d = LD_LOW;
        end
      end
      default: ld_state_d = LD_IDLE;
    endcase
  end

  // Loader registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ld_state_q <= LD_IDLE;
      slot_q     <= SLOT_CONFIG;
      ser_load_q <= 1'b0;
      latch_q    <= 16'h0000;
      cal_q      <= '0;
      ptr_q      <= 8'h00;
      pend_q     <= 1'b1;
      ref_q      <= 32'h0;
    end else begin
      ld_state_q <= ld_state_d;
      slot_q     <= slot_d;
      ser_load_q <= ser_load_d;
      latch_q    <= latch_d;
      cal_q      <= cal_d;
      ptr_q      <= ptr_d;
      pend_q     <= pend_d;
      ref_q      <= ref_d;
    end
  end

  // Byte writes and whole-page erase on the register port
  assign erase_hit  = reg_wr && reg_addr == REG_ERASE && reg_wdata[3:0] < 4'(PAGE_COUNT);
  assign erase_page = reg_wdata[3:0];

  always_ff @(posedge clock) begin
    if (reg_wr && reg_addr < 12'(MEM_BYTES)) begin
      mem[reg_addr[9:0]] <= reg_wdata[7:0];
    end else if (erase_hit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem[10'(erase_page * PAGE_BYTES + i)] <= 8'hff;
      end
    end
  end

  // Read data for the cycle after the strobe
  always_comb begin
    rdata_d = 16'h0000;
    if (reg_rd) begin
      if (reg_addr < 12'(MEM_BYTES)) begin
        rdata_d = {8'h00, mem[reg_addr[9:0]]};
      end else if (reg_addr == REG_STATUS) begin
        rdata_d = {6'h00, serial_enabled, learned_q, ptr_q};
      end else if (reg_addr == REG_BITCOUNT) begin
        rdata_d = {8'h00, bpc_q};
      end else if (reg_addr >= REG_CAL_BASE && reg_addr < REG_CAL_BASE + 12'(SLOT_COUNT)) begin
        rdata_d = cal_q[reg_addr[2:0]];
      end
    end
  end

  // Read data register, zero outside the answer cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // Calibration words to the analog trims
  assign cal_words = '{config_word:        cal_q[SLOT_CONFIG],
                       offset_trim_word:   cal_q[SLOT_OFS_TRIM],
                       offset_tempco_word: cal_q[SLOT_OFS_TEMPCO],
                       span_tempco_word:   cal_q[SLOT_SPAN_TEMPCO],
                       span_trim_word:     cal_q[SLOT_SPAN_TRIM]};

endmodule

// ===== dv/scel_loader_chk.sv
// Port-level assertions for the calibration loader
`timescale 1ns/10ps
module scel_loader_chk
  import scel_pkg::*;
#(
  parameter int unsigned REFRESH_CYCLES = REFRESH_CYC
) (
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        unlock_pin,
  input wire logic [7:0]  temp_code,
  input wire logic        single_pin_serial_io_i,
  input wire logic        single_pin_serial_io_o,
  input wire logic        single_pin_serial_io_oe,
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire scel_cal_t   cal_words,
  input wire logic        serial_enabled
);
  // One clock domain with asynchronous reset
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Serial pin is an input only and reads high when released
  a_pin_not_driven: assert property (!single_pin_serial_io_oe)
    else $error("serial pin enable raised");
  a_line_idle_high: assert property (single_pin_serial_io_o)
    else $error("serial pin output level low");
  // Read data appears only in the cycle after a read
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr[11:8] == 4'h3 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  // A byte written is read back unchanged
  a_byte_readback: assert property (reg_wr && reg_addr < 12'h300 ##1 reg_rd && reg_addr == $past(reg_addr)
    |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2)) else $error("memory byte readback differs");
  // Serial access gating
  a_unlock_enables: assert property (unlock_pin |-> serial_enabled)
    else $error("unlock pin does not enable serial");
  a_status_enable: assert property (reg_rd && reg_addr == REG_STATUS
    |=> reg_rdata[9] == $past(serial_enabled)) else $error("status enable bit wrong");
  a_bitcount_width: assert property (reg_rd && reg_addr == REG_BITCOUNT |=> reg_rdata[15:8] == 8'h00)
    else $error("bit period count exceeds 8 bits");
  // Words start from zero before the autoload fills them
  a_reset_clear: assert property ($rose(arst_n) |-> cal_words == '0)
    else $error("calibration words not cleared by reset");
endmodule

bind scel_loader scel_loader_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) chk_u (
  .clock                   (clock),
  .arst_n                  (arst_n),
  .unlock_pin              (unlock_pin),
  .temp_code               (temp_code),
  .single_pin_serial_io_i  (single_pin_serial_io_i),
  .single_pin_serial_io_o  (single_pin_serial_io_o),
  .single_pin_serial_io_oe (single_pin_serial_io_oe),
  .reg_addr                (reg_addr),
  .reg_wdata               (reg_wdata),
  .reg_wr                  (reg_wr),
  .reg_rd                  (reg_rd),
  .reg_rdata               (reg_rdata),
  .cal_words               (cal_words),
  .serial_enabled          (serial_enabled)
);

// ===== dv/scel_host_model.sv
// Host calibration computer driving the single-pin serial line
`timescale 1ns/10ps
module scel_host_model (
  output logic line
);
  // Line rests high between characters
  initial line = 1'b1;

  // One character: start, eight data bits LSB first, stop
  task automatic send_byte(input logic [7:0] data, input int unsigned bit_ns);
    wait ($realtime >= 1000000.0);
    #7;
    line = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      line = data[i];
      #(bit_ns);
    end
    line = 1'b1;
    #(bit_ns);
  endtask
endmodule

// ===== dv/scel_loader_test.sv
// Self-checking bench for the calibration loader
`timescale 1ns/10ps
module scel_loader_test
  import scel_pkg::*;
;
  localparam int unsigned RCYC = 200;
  localparam int unsigned B38K = 26042;
  localparam int unsigned B19K = 52083;
  typedef struct packed {
    logic [7:0] t;
    logic [9:0] oa;
    logic [9:0] sa;
  } scel_row_t;

  logic        clock;
  logic        arst_n;
  logic        unlock_pin;
  logic [7:0]  temp_code;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  scel_cal_t   cal_words;
  logic        serial_enabled;
  logic        sio_o;
  logic        sio_oe;
  logic        host_line;
  wire         sio_pin;
  logic [15:0] r;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  // Temperature code, then offset and span entry addresses; the last row clamps
  scel_row_t   rows [5] = '{'{8'h00, 10'h000, 10'h200}, '{8'h7f, 10'h0fe, 10'h2fe},
    '{8'h80, 10'h100, 10'h1a0}, '{8'haf, 10'h15e, 10'h1fe}, '{8'hc3, 10'h15e, 10'h1fe}};
  // Holding word 0xbeef into span tempco only; config is never rewritten
  logic [7:0]  cmd [5] = '{8'hf0, 8'he1, 8'he2, 8'hb3, 8'h39};

  // Line level from the design drive or the host
  assign sio_pin = sio_oe ? sio_o : host_line;

  scel_host_model host_u (
    .line (host_line)
  );

  scel_loader #(.REFRESH_CYCLES(RCYC)) dut_u (
    .clock                   (clock),
    .arst_n                  (arst_n),
    .unlock_pin              (unlock_pin),
    .temp_code               (temp_code),
    .single_pin_serial_io_i  (sio_pin),
    .single_pin_serial_io_o  (sio_o),
    .single_pin_serial_io_oe (sio_oe),
    .reg_addr                (reg_addr),
    .reg_wdata               (reg_wdata),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .cal_words               (cal_words),
    .serial_enabled          (serial_enabled)
  );

  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      results();
    end
  end

  // Memory pattern derived from the byte address
  function automatic logic [7:0] bv(input logic [9:0] a);
    return a[7:0] ^ {a[9:8], 6'h2d};
  endfunction
  function automatic logic [15:0] wd(input logic [9:0] a);
    return {bv(a + 10'h001), bv(a)};
  endfunction

  // Register port cycles, entered just after a rising edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask
  task automatic cycles(input int unsigned n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task automatic tx(input logic [7:0] b, input int unsigned ns);
    host_u.send_byte(b, ns);
    @(posedge clock);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    arst_n = 1'b0;
    unlock_pin = 1'b0;
    temp_code = 8'h41;
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 768; a++) begin
      wr(12'(a), {8'h00, bv(10'(a))});
    end
    wr({2'b00, LOCK_ADDR}, 16'h00ff);
    rd({2'b00, LOCK_ADDR}, r);
    chk("lock byte", 16'h00ff, {8'h00, r[7:0]});
    tdone("preload");
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk("words in reset", 16'h0000, {15'h0, cal_words !== '0});
    arst_n <= 1'b1;
    repeat (20) @(posedge clock);
    chk("config", wd(CONFIG_ADDR), cal_words.config_word);
    chk("offset tempco", wd(OFS_TEMPCO_ADDR), cal_words.offset_tempco_word);
    chk("span tempco", wd(SPAN_TEMPCO_ADDR), cal_words.span_tempco_word);
    chk("offset trim", wd(10'h082), cal_words.offset_trim_word);
    chk("span trim", wd(10'h282), cal_words.span_trim_word);
    rd(REG_STATUS, r);
    chk("status", 16'h0041, r);
    tdone("autoload");
    foreach (rows[i]) begin
      temp_code <= rows[i].t;
      cycles(RCYC + 20);
      chk("offset row", wd(rows[i].oa), cal_words.offset_trim_word);
      chk("span row", wd(rows[i].sa), cal_words.span_trim_word);
    end
    tdone("tables");
    wr(REG_ERASE, 16'h000b);
    rd(12'h2c0, r);
    chk("erased byte", 16'h00ff, {8'h00, r[7:0]});
    rd(12'h2bf, r);
    chk("kept byte", {8'h00, bv(10'h2bf)}, {8'h00, r[7:0]});
    wr(REG_ERASE, 16'h000c);
    rd(12'h000, r);
    chk("page 12 ignored", {8'h00, bv(10'h000)}, {8'h00, r[7:0]});
    rd(12'h300, r);
    chk("unmapped", 16'h0000, r);
    tdone("erase");
    tx(INIT_BYTE, B38K);
    rd(REG_STATUS, r);
    chk("locked learn", 16'h0000, {6'h00, r[9:8], 8'h00});
    unlock_pin <= 1'b1;
    cycles(2);
    chk("unlock pin", 16'h0001, {15'h0, serial_enabled});
    unlock_pin <= 1'b0;
    wr({2'b00, LOCK_ADDR}, {8'h00, LOCK_OPEN});
    cycles(2);
    chk("lock open", 16'h0001, {15'h0, serial_enabled});
    tdone("lock");
    tx(INIT_BYTE, B38K);
    rd(REG_BITCOUNT, r);
    chk("bit count fast", 16'h0010, r);
    for (int i = 0; i < 5; i++) begin
      tx(cmd[i], B38K);
    end
    cycles(4);
    chk("serial word", 16'hbeef, cal_words.span_tempco_word);
    cycles(RCYC + 20);
    chk("word kept", 16'hbeef, cal_words.span_tempco_word);
    // Same holding word steered into the span trim slot
    tx(8'h49, B38K);
    cycles(4);
    chk("serial trim", 16'hbeef, cal_words.span_trim_word);
    rd(REG_STATUS, r);
    chk("learned", 16'h0300, {6'h00, r[9:8], 8'h00});
    tx(REINIT_BYTE, B38K);
    rd(REG_STATUS, r);
    chk("relearn", 16'h0200, {6'h00, r[9:8], 8'h00});
    tx(INIT_BYTE, B19K);
    rd(REG_BITCOUNT, r);
    chk("bit count slow", 16'h0020, r);
    tdone("serial");
    results();
  end
endmodule
